// >>> src/dzf_regs.sv
// module: zero-flag, flag-pin function, digital volume and peak-level register bank of the playback path

module dzf_regs
    import dzf_pkg::*;
(
    input  wire logic                i_core_clk,
    input  wire logic                i_arst_n,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic [6:0]          i_reg_addr,
    input  wire logic [7:0]          i_reg_wdata,
    output logic      [7:0]          o_reg_rdata,
    output logic                     o_reg_rvalid,
    input  wire logic                i_sample_valid,
    input  wire logic [SAMPLE_W-1:0] i_left_sample,
    input  wire logic [SAMPLE_W-1:0] i_right_sample,
    input  wire logic                i_left_mute,
    input  wire logic                i_right_mute,
    input  wire logic                i_irq_req,
    output logic      [SAMPLE_W-1:0] o_left_sample,
    output logic      [SAMPLE_W-1:0] o_right_sample,
    output logic                     o_sample_valid,
    output logic                     o_left_flag_or_irq_pin,
    output logic                     o_right_flag_pin
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // gain for a 1/16 octave fraction, Q15
    function automatic logic [16:0] frac_gain(input logic [3:0] k);
        logic [16:0] g;
        g = 17'h08000;
        unique case (k)
            4'h0: g = 17'h08000;
            4'h1: g = 17'h07A98;
            4'h2: g = 17'h0756A;
            4'h3: g = 17'h07074;
            4'h4: g = 17'h06BB3;
            4'h5: g = 17'h06726;
            4'h6: g = 17'h062CA;
            4'h7: g = 17'h05E9E;
            4'h8: g = 17'h05A9E;
            4'h9: g = 17'h056CA;
            4'hA: g = 17'h0531F;
            4'hB: g = 17'h04F9C;
            4'hC: g = 17'h04C3F;
            4'hD: g = 17'h04906;
            4'hE: g = 17'h045F0;
            4'hF: g = 17'h042FC;
        endcase
        return g;
    endfunction : frac_gain

    // 0.375 dB per step below all-ones; 16 steps make one 6 dB halving
    function automatic logic [SAMPLE_W-1:0] attenuate(input logic [SAMPLE_W-1:0] s, input logic [7:0] code);
        logic [7:0]          steps;
        logic signed [40:0]  prod;
        logic signed [40:0]  shifted;
        steps   = ~code;
        prod    = $signed(s) * $signed(frac_gain(steps[3:0]));
        shifted = (prod >>> 15) >>> steps[7:4];
        return shifted[SAMPLE_W-1:0];
    endfunction : attenuate

    function automatic logic [MAG_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] a;
        a = s[SAMPLE_W-1] ? (~s + 24'h000001) : s;
        return a[SAMPLE_W-1] ? {MAG_W{1'b1}} : a[MAG_W-1:0];
    endfunction : magnitude

    // 6 dB per leading zero plus a mantissa correction, floored at -63 dBFS
    function automatic logic [5:0] peak_code(input logic [MAG_W-1:0] m);
        logic [4:0]       lz;
        logic             found;
        logic [MAG_W-1:0] norm;
        logic [2:0]       corr;
        logic [7:0]       db;
        lz    = 5'h00;
        found = 1'b0;
        for (int i = MAG_W - 1; i >= 0; i--) begin
            if (!found && m[i]) begin
                found = 1'b1;
            end else if (!found) begin
                lz = lz + 5'h01;
            end
        end
        norm = m << lz;
        unique case (norm[MAG_W-2 -: 3])
            3'h0: corr = 3'h6;
            3'h1: corr = 3'h5;
            3'h2: corr = 3'h4;
            3'h3: corr = 3'h3;
            3'h4: corr = 3'h2;
            3'h5: corr = 3'h2;
            3'h6: corr = 3'h1;
            3'h7: corr = 3'h1;
        endcase
        db = 8'(lz) * 8'h06 + 8'(corr);
        if (!found || db > 8'(PEAK_CODE_FLOOR)) begin
            db = 8'(PEAK_CODE_FLOOR);
        end
        if (m == {MAG_W{1'b1}}) begin
            db = 8'h00;
        end
        return db[5:0];
    endfunction : peak_code

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dzf_state_type st_q;
    dzf_state_type st_d;

    logic [MAG_W-1:0] mag_l;
    logic [MAG_W-1:0] mag_r;
    logic             zdat_l;
    logic             zdat_r;
    logic             flag_l;
    logic             flag_r;
    logic             act_l;
    logic             act_r;
    logic             pol;
    logic [1:0]       rsel;

    always_comb begin
        st_d   = st_q;
        mag_l  = magnitude(i_left_sample);
        mag_r  = magnitude(i_right_sample);
        pol    = st_q.zf_cfg[FLAG_POLARITY_BIT];
        rsel   = st_q.pin_cfg[1:0];

        // zero-data run counters, saturating
        if (i_sample_valid) begin
            st_d.zr_l = (i_left_sample != '0) ? '0 :
                        (st_q.zr_l == ZERO_RUN_SAMPLES) ? st_q.zr_l : st_q.zr_l + 11'h001;
            st_d.zr_r = (i_right_sample != '0) ? '0 :
                        (st_q.zr_r == ZERO_RUN_SAMPLES) ? st_q.zr_r : st_q.zr_r + 11'h001;
        end
        zdat_l = (st_q.zr_l == ZERO_RUN_SAMPLES);
        zdat_r = (st_q.zr_r == ZERO_RUN_SAMPLES);

        // raw per-channel zero flags
        flag_l = (!st_q.zf_cfg[MUTE_VOLUME_FLAG_DISABLE_BIT]
                  && (i_left_mute || st_q.vol_l == VOLUME_ZERO_CODE))
              || (!st_q.zf_cfg[ZERO_DATA_FLAG_DISABLE_BIT] && zdat_l);
        flag_r = (!st_q.zf_cfg[MUTE_VOLUME_FLAG_DISABLE_BIT]
                  && (i_right_mute || st_q.vol_r == VOLUME_ZERO_CODE))
              || (!st_q.zf_cfg[ZERO_DATA_FLAG_DISABLE_BIT] && zdat_r);

        // pin functions
        unique case (dzf_rsel_type'(rsel))
            RSEL_RIGHT:  act_r = flag_r;
            RSEL_LEFT:   act_r = flag_l;
            RSEL_EITHER: act_r = flag_l || flag_r;
            RSEL_BOTH:   act_r = flag_l && flag_r;
        endcase
        if (st_q.pin_cfg[SHARED_PIN_IRQ_SELECT_BIT - RIGHT_PIN_FUNCTION_SELECT_LSB]) begin
            act_l      = 1'b0;
            st_d.pin_l = i_irq_req;
            st_d.pin_r = act_r ^ pol;
        end else begin
            act_l      = flag_l;
            st_d.pin_l = act_l ^ pol;
            st_d.pin_r = flag_r ^ pol;
        end

        // volume datapath
        st_d.out_v = i_sample_valid;
        if (i_sample_valid) begin
            st_d.out_l = attenuate(i_left_sample, st_q.vol_l);
            st_d.out_r = attenuate(i_right_sample, st_q.vol_r);
            if (mag_l > st_q.pk_l) begin
                st_d.pk_l = mag_l;
            end
            if (mag_r > st_q.pk_r) begin
                st_d.pk_r = mag_r;
            end
        end

        // register writes, reserved bits dropped
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                ZERO_FLAG_CONFIG_ADDR:         st_d.zf_cfg  = i_reg_wdata[2:0];
                FLAG_PIN_FUNCTION_SELECT_ADDR: st_d.pin_cfg = i_reg_wdata[6:4];
                LEFT_VOLUME_ADDR:              st_d.vol_l   = i_reg_wdata;
                RIGHT_VOLUME_ADDR:             st_d.vol_r   = i_reg_wdata;
                default: ;
            endcase
        end

        // register reads; a peak read restarts the hold from the current sample
        st_d.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                ZERO_FLAG_CONFIG_ADDR:         st_d.rdata = {5'h00, st_q.zf_cfg};
                FLAG_PIN_FUNCTION_SELECT_ADDR: st_d.rdata = {1'b0, st_q.pin_cfg, 4'h0};
                LEFT_VOLUME_ADDR:              st_d.rdata = st_q.vol_l;
                RIGHT_VOLUME_ADDR:             st_d.rdata = st_q.vol_r;
                LEFT_PEAK_LEVEL_ADDR: begin
                    st_d.rdata = {2'h0, peak_code(st_q.pk_l)};
                    st_d.pk_l  = i_sample_valid ? mag_l : '0;
                end
                RIGHT_PEAK_LEVEL_ADDR: begin
                    st_d.rdata = {2'h0, peak_code(st_q.pk_r)};
                    st_d.pk_r  = i_sample_valid ? mag_r : '0;
                end
                default:                       st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q         <= '0;
            st_q.zf_cfg  <= ZERO_FLAG_CONFIG_RESET[2:0];
            st_q.pin_cfg <= FLAG_PIN_FUNCTION_SELECT_RESET[6:4];
            st_q.vol_l   <= VOLUME_RESET;
            st_q.vol_r   <= VOLUME_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata            = st_q.rdata;
    assign o_reg_rvalid           = st_q.rvalid;
    assign o_left_sample          = st_q.out_l;
    assign o_right_sample         = st_q.out_r;
    assign o_sample_valid         = st_q.out_v;
    assign o_left_flag_or_irq_pin = st_q.pin_l;
    assign o_right_flag_pin       = st_q.pin_r;

endmodule : dzf_regs

// >>> src/dzf_pkg.sv
// package: register map, field layout and types of the playback flag/volume/peak register bank
package dzf_pkg;

    // ------------------------------------------------------------
    // register addresses (control port, 7-bit)
    // ------------------------------------------------------------
    localparam logic [6:0] ZERO_FLAG_CONFIG_ADDR         = 7'h66;
    localparam logic [6:0] FLAG_PIN_FUNCTION_SELECT_ADDR = 7'h67;
    localparam logic [6:0] LEFT_VOLUME_ADDR              = 7'h68;
    localparam logic [6:0] RIGHT_VOLUME_ADDR             = 7'h69;
    localparam logic [6:0] LEFT_PEAK_LEVEL_ADDR          = 7'h6A;
    localparam logic [6:0] RIGHT_PEAK_LEVEL_ADDR         = 7'h6B;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MUTE_VOLUME_FLAG_DISABLE_BIT  = 2;
    localparam int ZERO_DATA_FLAG_DISABLE_BIT    = 1;
    localparam int FLAG_POLARITY_BIT             = 0;
    localparam int SHARED_PIN_IRQ_SELECT_BIT     = 6;
    localparam int RIGHT_PIN_FUNCTION_SELECT_LSB = 4;

    // implemented bit masks (peak code is read-only), everything else reads zero
    localparam logic [7:0] ZERO_FLAG_CONFIG_MASK         = 8'h07;
    localparam logic [7:0] FLAG_PIN_FUNCTION_SELECT_MASK = 8'h70;
    localparam logic [7:0] PEAK_CODE_MASK                = 8'h3F;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ZERO_FLAG_CONFIG_RESET         = 8'h00;
    localparam logic [7:0] FLAG_PIN_FUNCTION_SELECT_RESET = 8'h00;
    localparam logic [7:0] VOLUME_RESET                   = 8'hFF;

    // ------------------------------------------------------------
    // datapath constants
    // ------------------------------------------------------------
    localparam int          SAMPLE_W         = 24;
    localparam int          MAG_W            = 23;
    localparam int          ZERO_RUN_W       = 11;
    localparam logic [10:0] ZERO_RUN_SAMPLES = 11'h400;
    localparam logic [5:0]  PEAK_CODE_FLOOR  = 6'h3F;
    localparam logic [7:0]  VOLUME_ZERO_CODE = 8'h00;

    // right pin function when the shared pin is an interrupt
    typedef enum logic [1:0] {
        RSEL_RIGHT  = 2'h0,
        RSEL_LEFT   = 2'h1,
        RSEL_EITHER = 2'h2,
        RSEL_BOTH   = 2'h3
    } dzf_rsel_type;

    typedef struct packed {
        logic [2:0]            zf_cfg;
        logic [2:0]            pin_cfg;
        logic [7:0]            vol_l;
        logic [7:0]            vol_r;
        logic [MAG_W-1:0]      pk_l;
        logic [MAG_W-1:0]      pk_r;
        logic [ZERO_RUN_W-1:0] zr_l;
        logic [ZERO_RUN_W-1:0] zr_r;
        logic [SAMPLE_W-1:0]   out_l;
        logic [SAMPLE_W-1:0]   out_r;
        logic                  out_v;
        logic                  pin_l;
        logic                  pin_r;
        logic [7:0]            rdata;
        logic                  rvalid;
    } dzf_state_type;

endpackage : dzf_pkg

// >>> tb/dzf_regs_monitor.sv
// checker: register port, sample strobe and flag pin relations of the register bank
module dzf_regs_monitor
    import dzf_pkg::*;
(
    input wire logic       i_core_clk,
    input wire logic       i_arst_n,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_rvalid,
    input wire logic       i_sample_valid,
    input wire logic       i_left_mute,
    input wire logic       i_right_mute,
    input wire logic       i_irq_req,
    input wire logic       o_sample_valid,
    input wire logic       o_left_flag_or_irq_pin,
    input wire logic       o_right_flag_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // shadow of written settings
    // ----
    logic [2:0] zf_q;
    logic [2:0] pc_q;
    logic [7:0] vl_q;
    logic [7:0] vr_q;
    logic       live_q;
    logic       fl;
    logic       fr;
    logic       sel;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            zf_q <= 3'h0;
            pc_q <= 3'h0;
            vl_q <= 8'hFF;
            vr_q <= 8'hFF;
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
            if (i_reg_wr && i_reg_addr == ZERO_FLAG_CONFIG_ADDR) zf_q <= i_reg_wdata[2:0];
            if (i_reg_wr && i_reg_addr == FLAG_PIN_FUNCTION_SELECT_ADDR) pc_q <= i_reg_wdata[6:4];
            if (i_reg_wr && i_reg_addr == LEFT_VOLUME_ADDR) vl_q <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == RIGHT_VOLUME_ADDR) vr_q <= i_reg_wdata;
        end
    end
    assign fl = !zf_q[2] && (i_left_mute || vl_q == 8'h00);
    assign fr = !zf_q[2] && (i_right_mute || vr_q == 8'h00);
    assign sel = pc_q[1] ? (pc_q[0] ? (fl && fr) : (fl || fr)) : (pc_q[0] ? fl : fr);
    // ----
    // assertions
    // ----
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    cfg_readback_a: assert property (o_reg_rvalid && $past(i_reg_addr) == ZERO_FLAG_CONFIG_ADDR
        |-> o_reg_rdata == {5'h00, $past(zf_q)}) else $error("zero flag config readback wrong");
    pin_readback_a: assert property (o_reg_rvalid && $past(i_reg_addr) == FLAG_PIN_FUNCTION_SELECT_ADDR
        |-> o_reg_rdata == {1'b0, $past(pc_q), 4'h0}) else $error("pin select readback wrong");
    vol_readback_a: assert property (o_reg_rvalid && $past(i_reg_addr) == LEFT_VOLUME_ADDR
        |-> o_reg_rdata == $past(vl_q)) else $error("left volume readback wrong");
    peak_reserved_a: assert property (o_reg_rvalid && $past(i_reg_addr[6:1]) == 6'h35
        |-> o_reg_rdata[7:6] == 2'h0) else $error("peak reserved bits set");
    read_answer_a: assert property (live_q |-> o_reg_rvalid == $past(i_reg_rd)) else $error("read answer timing");
    strobe_delay_a: assert property (live_q |-> o_sample_valid == $past(i_sample_valid))
        else $error("sample strobe timing");
    irq_pass_a: assert property (live_q && $past(pc_q[2]) |-> o_left_flag_or_irq_pin == $past(i_irq_req))
        else $error("shared pin not irq");
    left_flag_a: assert property (live_q && !$past(pc_q[2]) && $past(zf_q[1])
        |-> o_left_flag_or_irq_pin == ($past(fl) ^ $past(zf_q[0]))) else $error("left flag pin wrong");
    right_flag_a: assert property (live_q && !$past(pc_q[2]) && $past(zf_q[1])
        |-> o_right_flag_pin == ($past(fr) ^ $past(zf_q[0]))) else $error("right flag pin wrong");
    right_select_a: assert property (live_q && $past(pc_q[2]) && $past(zf_q[1])
        |-> o_right_flag_pin == ($past(sel) ^ $past(zf_q[0]))) else $error("right pin select wrong");
    cover property (pc_q[2] && o_right_flag_pin);
    cover property (o_sample_valid);
    cover property (o_reg_rvalid && zf_q[0]);
endmodule : dzf_regs_monitor

bind dzf_regs dzf_regs_monitor u_mon (.*);

// >>> tb/dzf_host_model.sv
// model: host controller issuing control-port accesses
module dzf_host_model
    import dzf_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_reg_rdata,
    input  wire logic       i_reg_rvalid,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic [6:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 7'h00;
        o_reg_wdata = 8'h00;
    end
    // reserved bits are written as zero unless raw is set
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input bit raw);
        @(negedge i_core_clk);
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = raw ? d : d & (a == ZERO_FLAG_CONFIG_ADDR ? ZERO_FLAG_CONFIG_MASK :
            a == FLAG_PIN_FUNCTION_SELECT_ADDR ? FLAG_PIN_FUNCTION_SELECT_MASK : 8'hFF);
        @(negedge i_core_clk);
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~o_reg_wdata;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(negedge i_core_clk);
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(negedge i_core_clk);
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        d = i_reg_rdata;
        v = i_reg_rvalid;
    endtask : rd
endmodule : dzf_host_model

// >>> tb/tb.sv
// testbench: reference model of volume, flag pins and peak code against the register bank
module tb
    import dzf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr, rd, rv, sv, osv, ml, mr, irq, pl, pr, v, fl, fr;
    logic [6:0] addr;
    logic [7:0] wd, rdat, d, vc;
    logic [2:0] c, p;
    logic [23:0] sl, sr, ol, orr, a, b;
    longint mxl, mxr;
    int fail_count, checks;
    dzf_regs DUT (.i_core_clk(clk), .i_arst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_sample_valid(sv), .i_left_sample(sl),
        .i_right_sample(sr), .i_left_mute(ml), .i_right_mute(mr), .i_irq_req(irq), .o_left_sample(ol),
        .o_right_sample(orr), .o_sample_valid(osv), .o_left_flag_or_irq_pin(pl), .o_right_flag_pin(pr));
    dzf_host_model u_host (.i_core_clk(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----
    // reference model and helpers
    // ----
    function automatic logic [23:0] att(input logic [23:0] s, input int code);
        int g[16] = '{'h8000, 'h7A98, 'h756A, 'h7074, 'h6BB3, 'h6726, 'h62CA, 'h5E9E,
                      'h5A9E, 'h56CA, 'h531F, 'h4F9C, 'h4C3F, 'h4906, 'h45F0, 'h42FC};
        int st = 255 - code;
        longint q = longint'($signed(s)) * g[st % 16];
        return 24'((q >>> 15) >>> (st / 16));
    endfunction : att
    function automatic longint mag(input logic [23:0] s);
        longint m = longint'($signed(s));
        m = m < 0 ? -m : m;
        return m > 'h7FFFFF ? 'h7FFFFF : m;
    endfunction : mag
    function automatic logic [23:0] pk(input longint m);
        int cr[8] = '{6, 5, 4, 3, 2, 2, 1, 1};
        int k = 22;
        int r;
        if (m == 0) return 24'h3F;
        if (m == 'h7FFFFF) return 24'h0;
        while (!m[k]) k--;
        r = 6 * (22 - k) + cr[((m << 3) >> k) & 7];
        return 24'(r > 63 ? 63 : r);
    endfunction : pk
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [6:0] ra, input logic [23:0] e);
        u_host.rd(ra, d, v);
        chk({15'h0, v, d}, {16'h1, e[7:0]});
    endtask : rchk
    task automatic send(input logic [23:0] x, input logic [23:0] y);
        @(negedge clk);
        sv = 1'b1;
        sl = x;
        sr = y;
        @(negedge clk);
        sv = 1'b0;
        sl = ~x;
        sr = ~y;
    endtask : send
    task automatic wrap_up;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
    // ----
    // main sequence
    // ----
    initial begin
        {rst_n, sv, ml, mr, irq, sl, sr, fail_count, checks} = '0;
        void'($urandom(89054));
        repeat (6) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        rchk(7'h66, 24'h00); rchk(7'h67, 24'h00); rchk(7'h68, 24'hFF); rchk(7'h10, 24'h00);
        u_host.wr(7'h66, 8'hFF, 1); u_host.wr(7'h67, 8'hFF, 1); u_host.wr(7'h6A, 8'hFF, 1);
        rchk(7'h66, 24'h07); rchk(7'h67, 24'h70);
        for (int i = 0; i < 40; i++) begin
            vc = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom);
            u_host.wr(7'h68, vc, 0); u_host.wr(7'h69, ~vc, 0);
            a = 24'($urandom); b = 24'($urandom);
            send(a, b);
            chk(24'(osv), 24'h1); chk(ol, att(a, vc)); chk(orr, att(b, 255 - vc));
        end
        for (int k = 0; k < 512; k++) begin
            c = k[2:0]; p = k[5:3]; vc = k[8] ? 8'h00 : 8'hFF;
            u_host.wr(7'h66, {5'h0, c}, 0); u_host.wr(7'h67, {1'b0, p, 4'h0}, 0);
            u_host.wr(7'h68, vc, 0); u_host.wr(7'h69, vc, 0);
            @(negedge clk) {ml, mr, irq} = {k[7:6], 1'($urandom)};
            repeat (2) @(negedge clk);
            fl = !c[2] && (ml || k[8]); fr = !c[2] && (mr || k[8]);
            chk(24'(pl), 24'(p[2] ? irq : fl ^ c[0]));
            chk(24'(pr), 24'((p[2] ? (p[1] ? (p[0] ? fl & fr : fl | fr) : (p[0] ? fl : fr)) : fr) ^ c[0]));
        end
        {ml, mr} = 2'b00;
        u_host.wr(7'h66, 8'h00, 0); u_host.wr(7'h67, 8'h00, 0); u_host.wr(7'h68, 8'hFF, 0); u_host.wr(7'h69, 8'hFF, 0);
        send(24'h1, 24'h1);
        for (int i = 0; i < 1023; i++) send(24'h0, 24'h1);
        chk(24'(pl), 24'h0);
        send(24'h0, 24'h1);
        @(negedge clk);
        chk(24'({pl, pr}), 24'h2);
        u_host.wr(7'h66, 8'h02, 0);
        @(negedge clk);
        chk(24'(pl), 24'h0);
        u_host.rd(7'h6A, d, v); u_host.rd(7'h6B, d, v);
        for (int r = 0; r < 4; r++) begin
            {mxl, mxr} = '0;
            for (int i = 0; i < 5; i++) begin
                a = r == 0 && i == 0 ? 24'h800000 : 24'($urandom) >> ($urandom % 24);
                b = r == 1 ? 24'h0 : 24'($urandom) >> ($urandom % 24);
                send(a, b);
                mxl = mag(a) > mxl ? mag(a) : mxl; mxr = mag(b) > mxr ? mag(b) : mxr;
            end
            rchk(7'h6A, pk(mxl));
            rchk(7'h6B, pk(mxr));
        end
        wrap_up();
    end
endmodule : tb
